// ---- verilog/mcs_pkg.sv ----
package mcs_pkg;

    // Word layout of the serial port
    localparam int WORD_W         = 16;
    localparam int BANK_SEL_BIT   = 15;

    // Bank 0 fields
    localparam int B0_BLANK_LSB   = 0;
    localparam int B0_MINOFF_A    = 6;
    localparam int B0_CONV_SW_LSB = 7;
    localparam int B0_CHOP_LSB    = 10;
    localparam int B0_RST_DELAY   = 12;
    localparam int B0_LDO_SW      = 13;
    localparam int B0_MINOFF_B    = 14;

    // Bank 1 fields
    localparam int B1_SHORT_LSB   = 0;
    localparam int B1_MINOFF_C    = 7;
    localparam int B1_DEEP_SLEEP  = 11;
    localparam int B1_SENSE_STEP  = 4;
    localparam int B1_SENSE_LSB   = 4;

    // Extended fields
    localparam int EX_SEL_LSB     = 0;
    localparam int EX_ISD_MASK    = 4;
    localparam int EX_VSD_MASK    = 5;
    localparam int EX_MOTOR_MASK  = 6;
    localparam int EX_TSD_MASK    = 7;
    localparam int EX_RMASK_C     = 8;
    localparam int EX_RMASK_B     = 9;
    localparam int EX_RMASK_A     = 10;
    localparam int EX_RMASK_SR    = 11;
    localparam int EX_TWARN_MODE  = 12;
    localparam int EX_TSD_LSB     = 13;
    localparam int EX_MOTOR_SHORT_DETECT_CONT   = 15;

    // Reset values
    localparam logic [15:0] B0_RESET_BASE = 16'h0080;
    localparam logic [15:0] B1_RESET      = 16'h0000;
    localparam logic [15:0] EX_RESET      = 16'h0000;

    // Thermal policy codes
    localparam logic [1:0] TSD_HOLD_A  = 2'h0;
    localparam logic [1:0] TSD_KEEP_HI = 2'h1;
    localparam logic [1:0] TSD_PULSE   = 2'h2;

    // Identification bits, values arbitrary
    localparam logic [2:0] REVISION_CODE = 3'h1;
    localparam logic [1:0] DEVICE_CODE   = 2'h2;

    // Timing
    localparam int CLK_KHZ          = 10_000;
    localparam int RST_DELAY_NS     = 100_000;
    localparam int RST_DELAY_CYCLES = (RST_DELAY_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int RST_PULSE_MS     = 40;
    localparam int RST_PULSE_CYCLES = RST_PULSE_MS * CLK_KHZ;

    // Channel index: 0 A, 1 B, 2 C, 3 linear regulator
    typedef struct packed {
        logic [3:0] reg_ocp;
        logic [3:0] reg_uvp;
        logic [3:0] reg_ovp;
        logic       motor_ocp;
        logic       thermal;
    } mcs_fault_t;

    typedef struct packed {
        logic [2:0][2:0] bridge_blank_periods;
        logic [1:0][2:0] short_blank_periods;
        logic [7:0]      chop_khz;
        logic [2:0]      minoff_long;
        logic [2:0]      converter_on;
        logic            ldo_on;
        logic [2:0]      sense_external;
        logic [2:0][1:0] trip_code;
        logic            deep_sleep;
        logic            thermal_analog;
        logic            reset_delay_en;
    } mcs_cfg_t;

endpackage

// ---- verilog/mcs_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pins entering the oscillator domain
module mcs_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage only feeds the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ---- verilog/mcs_link.sv ----
`timescale 1ns/1ps
// Serial shift chain on the host clock and capture on the latch edge
module mcs_link (
    input  wire logic        link_clk,
    input  wire logic        reset_n,
    input  wire logic        serial_data,
    input  wire logic        latch_pulse_pin,
    output logic      [16:0] latched_word,
    output logic             latch_toggle
);

    logic [15:0] shift_q;

    // Falling-edge sampling; runs regardless of standby, no reset since clock may stop
    always_ff @(negedge link_clk) begin
        shift_q <= {shift_q[14:0], serial_data};
    end

    // Address bit on top, payload below; held stable until the next latch edge
    always_ff @(posedge latch_pulse_pin) begin
        latched_word <= {serial_data, shift_q};
    end

    // Toggle announces a new word to the oscillator domain
    always_ff @(posedge latch_pulse_pin or negedge reset_n) begin
        if (!reset_n) begin
            latch_toggle <= 1'b0;
        end else begin
            latch_toggle <= ~latch_toggle;
        end
    end

endmodule

// ---- verilog/mcs_config.sv ----
`timescale 1ns/1ps
// How it works
// - Latch while standby low routes word: data low setup, data high extended.
// - Shift chain runs on every clock whatever standby does; latch commits.
// - Data line sampled on falling serial clock edge, up to 25 MHz.
// - Data level at latch rise is a select bit, not payload.
// - Standby low forces all bridges off and high impedance, any time.
// - Bridge blanking codes 00..11 give 3,2,4,5 oscillator/8 periods.
// - Minimum off-time bits: A bank0 bit6, B bank0 bit14, C bank1 bit7.
// - Bank0 bits 10-11 choose chopping 100, 50, 133, 200 kHz.
// - Bank0 bits 7-9 switch converters, 0 on; A resets off, B/C from strap.
// - Reset-delay bit postpones reset output assertion by about 100 us.
// - Word bit 15 selects bank 0 or bank 1.
// - Undervoltage or external reset low returns every bit to default.
// - Regulator enable default equals converter B default from strap.
// - Short-detect blanking codes give 3,2,4,5 minimum oscillator/4 periods.
// - Sense bit picks internal or external sensing; two-bit trip code.
// - Bank1 bit 11 enters deep sleep, all but wake path disabled.
// - Extended bits 0-3 pick status output, valid within 4000 ns.
// - Extended bits 4-11 mask fault classes and per-channel reset action.
// - Extended bit 12 chooses digital warning or analog temperature output.
// - Thermal fault stops motors; code chooses regulator and reset behaviour.
// - Motor overcurrent, control 0: stop bridges, pulse reset, release on standby rise.
// - Overcurrent on any bridge stops all bridges together.
// - Status codes: fault flags low, identity bits, regulator fault, fixed high.
// - Every fault reset pulse lasts 40 ms.
// - Reset-mask set confines regulator fault; clear shuts everything down.
module mcs_config #(
    parameter int PULSE_CYCLES = mcs_pkg::RST_PULSE_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               link_clk,
    input  wire logic               serial_data,
    input  wire logic               latch_pulse_pin,
    input  wire logic               drive_standby_l,
    input  wire logic               system_reset_in_l,
    input  wire logic               supply_undervolt,
    input  wire logic               wake_request_l,
    input  wire logic [1:0]         startup_select_pin,
    input  wire mcs_pkg::mcs_fault_t fault_in,
    output logic      [2:0]         bridge_enable,
    output mcs_pkg::mcs_cfg_t       cfg_out,
    output logic                    status_mux_out,
    output logic                    supervisor_reset_out_l
);

    // Code to period count, shared by both blanking kinds
    function automatic logic [2:0] blank_periods(input logic [1:0] code);
        case (code)
            2'h0:    blank_periods = 3'h3;
            2'h1:    blank_periods = 3'h2;
            2'h2:    blank_periods = 3'h4;
            default: blank_periods = 3'h5;
        endcase
    endfunction

    // Bank 0 default depends on the captured strap
    function automatic logic [15:0] bank0_default(input logic [1:0] strap);
        logic b_off;
        logic c_off;
        logic [15:0] v;
        b_off = (strap == 2'h0);
        c_off = (strap != 2'h2) && (strap != 2'h3);
        v = mcs_pkg::B0_RESET_BASE;
        v[mcs_pkg::B0_CONV_SW_LSB + 1] = b_off;
        v[mcs_pkg::B0_CONV_SW_LSB + 2] = c_off;
        v[mcs_pkg::B0_LDO_SW] = b_off;
        bank0_default = v;
    endfunction

    logic [16:0]         link_word;
    logic                link_tog;
    logic                tog_sync;
    logic                tog_seen_q;
    logic [3:0]          pins_sync;
    logic [1:0]          strap_sync;
    mcs_pkg::mcs_fault_t flt;
    logic                standby_l_prev_q;

    // Serial front end in the host clock domain
    mcs_link u_link (
        .link_clk        (link_clk),
        .reset_n         (reset_n),
        .serial_data     (serial_data),
        .latch_pulse_pin (latch_pulse_pin),
        .latched_word    (link_word),
        .latch_toggle    (link_tog)
    );

    // Level pins into the oscillator domain
    mcs_sync #(.W(5), .RST_VAL(5'h05)) u_sync_pins (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({link_tog, drive_standby_l, system_reset_in_l, supply_undervolt,
                    wake_request_l}),
        .sync_out ({tog_sync, pins_sync})
    );

    // Strap stages never reset, so they already hold the pin when reset ends
    mcs_sync #(.W(2)) u_sync_strap (
        .clk      (clk),
        .reset_n  (1'b1),
        .async_in (startup_select_pin),
        .sync_out (strap_sync)
    );

    mcs_sync #(.W($bits(mcs_pkg::mcs_fault_t))) u_sync_faults (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (fault_in),
        .sync_out (flt)
    );

    logic standby_l;
    logic ext_rst_l;
    logic undervolt;
    logic wake_l;
    assign standby_l = pins_sync[3];
    assign ext_rst_l = pins_sync[2];
    assign undervolt = pins_sync[1];
    assign wake_l    = pins_sync[0];

    logic clear;
    logic commit;
    logic standby_rise;
    assign clear        = !reset_n || undervolt || !ext_rst_l;
    assign commit       = (tog_sync != tog_seen_q) && !standby_l;
    assign standby_rise = standby_l && !standby_l_prev_q;

    // New-word detection; seen value follows the toggle during reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tog_seen_q       <= tog_sync;
            standby_l_prev_q <= 1'b0;
        end else begin
            tog_seen_q       <= tog_sync;
            standby_l_prev_q <= standby_l;
        end
    end

    logic [15:0] bank0_q;
    logic [15:0] bank1_q;
    logic [15:0] ext_q;
    logic [15:0] payload;
    logic        to_ext;
    assign payload = link_word[15:0];
    assign to_ext  = link_word[16];

    // Setup and extended registers; whole word lands in one cycle
    always_ff @(posedge clk) begin
        if (clear) begin
            bank0_q <= bank0_default(strap_sync);
            bank1_q <= mcs_pkg::B1_RESET;
            ext_q   <= mcs_pkg::EX_RESET;
        end else if (commit) begin
            if (to_ext) begin
                ext_q <= payload;
            end else if (!payload[mcs_pkg::BANK_SEL_BIT]) begin
                bank0_q <= payload;
            end else begin
                bank1_q <= payload;
            end
        end else if (!wake_l) begin
            bank1_q[mcs_pkg::B1_DEEP_SLEEP] <= 1'b0;
        end
    end

    logic deep_sleep;
    assign deep_sleep = bank1_q[mcs_pkg::B1_DEEP_SLEEP];

    // Per-channel regulator faults with class masks; mask bit 1 ignores the class
    logic [3:0] reg_fault;
    logic [3:0] sel_mask;
    assign reg_fault = (flt.reg_ocp & {4{!ext_q[mcs_pkg::EX_ISD_MASK]}})
                     | ((flt.reg_uvp | flt.reg_ovp) & {4{!ext_q[mcs_pkg::EX_VSD_MASK]}});
    assign sel_mask  = {ext_q[mcs_pkg::EX_RMASK_SR], ext_q[mcs_pkg::EX_RMASK_C],
                        ext_q[mcs_pkg::EX_RMASK_B], ext_q[mcs_pkg::EX_RMASK_A]};

    logic       tsd_set;
    logic       ocp_set;
    logic       tsd_q;
    logic [1:0] tsd_code_q;
    logic       ocp_q;
    logic [3:0] reg_off_q;
    logic       global_q;
    logic       tsd_soft;
    assign tsd_set  = flt.thermal && !ext_q[mcs_pkg::EX_TSD_MASK];
    assign ocp_set  = flt.motor_ocp && !ext_q[mcs_pkg::EX_MOTOR_MASK];
    assign tsd_soft = (tsd_code_q == mcs_pkg::TSD_KEEP_HI) || (tsd_code_q == mcs_pkg::TSD_PULSE);

    // Fault latches; a fault still present wins over a release in the same cycle
    always_ff @(posedge clk) begin
        if (clear) begin
            tsd_q      <= 1'b0;
            tsd_code_q <= mcs_pkg::TSD_HOLD_A;
            ocp_q      <= 1'b0;
            reg_off_q  <= 4'h0;
            global_q   <= 1'b0;
        end else begin
            if (tsd_set && !tsd_q) begin
                tsd_code_q <= ext_q[mcs_pkg::EX_TSD_LSB +: 2];
            end
            tsd_q     <= tsd_set || (tsd_q && !(standby_rise && tsd_soft));
            ocp_q     <= ocp_set || (ocp_q && !(standby_rise &&
                                     !ext_q[mcs_pkg::EX_MOTOR_SHORT_DETECT_CONT]));
            reg_off_q <= (reg_fault & sel_mask)
                       | (reg_off_q & {4{!standby_rise}});
            global_q  <= global_q || |(reg_fault & ~sel_mask);
        end
    end

    logic tsd_hard;
    logic motors_stop;
    logic regs_down;
    assign tsd_hard    = tsd_q && !tsd_soft;
    assign motors_stop = clear || !standby_l || tsd_q || ocp_q || global_q || deep_sleep;
    assign regs_down   = clear || tsd_hard || global_q || deep_sleep;

    // Bridges stop together; outputs go high impedance when disabled
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bridge_enable <= 3'h0;
        end else begin
            bridge_enable <= {3{!motors_stop}};
        end
    end

    // Fault reset pulse; started on entry into a pulsing fault state
    logic [19:0] pulse_cnt_q;
    logic        tsd_q_prev_q;
    logic        ocp_q_prev_q;
    logic        pulse_start;
    assign pulse_start = (tsd_q && !tsd_q_prev_q && tsd_code_q == mcs_pkg::TSD_PULSE)
                       || (ocp_q && !ocp_q_prev_q && !ext_q[mcs_pkg::EX_MOTOR_SHORT_DETECT_CONT]);

    always_ff @(posedge clk) begin
        if (clear) begin
            pulse_cnt_q  <= 20'h00000;
            tsd_q_prev_q <= 1'b0;
            ocp_q_prev_q <= 1'b0;
        end else begin
            tsd_q_prev_q <= tsd_q;
            ocp_q_prev_q <= ocp_q;
            if (pulse_start) begin
                pulse_cnt_q <= 20'(PULSE_CYCLES);
            end else if (pulse_cnt_q != 20'h00000) begin
                pulse_cnt_q <= pulse_cnt_q - 20'h00001;
            end
        end
    end

    // Reset output with optional assertion delay; release is immediate
    logic        rst_req;
    logic [10:0] delay_cnt_q;
    assign rst_req = clear || tsd_hard || global_q || (pulse_cnt_q != 20'h00000);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            delay_cnt_q            <= 11'h000;
            supervisor_reset_out_l <= 1'b0;
        end else if (!rst_req) begin
            delay_cnt_q            <= 11'h000;
            supervisor_reset_out_l <= 1'b1;
        end else if (!bank0_q[mcs_pkg::B0_RST_DELAY]
                     || delay_cnt_q == 11'(mcs_pkg::RST_DELAY_CYCLES - 1)) begin
            supervisor_reset_out_l <= 1'b0;
        end else begin
            delay_cnt_q <= delay_cnt_q + 11'h001;
        end
    end

    // Status selector; registered so it settles well inside the allowed time
    logic [15:0] status_vec;
    always_comb begin
        status_vec     = 16'hFFFF;
        status_vec[0]  = !reg_fault[0] && !reg_off_q[0];
        status_vec[1]  = !reg_fault[1] && !reg_off_q[1];
        status_vec[2]  = !reg_fault[2] && !reg_off_q[2];
        status_vec[3]  = !(|flt.reg_ocp);
        status_vec[4]  = !(|flt.reg_uvp);
        status_vec[5]  = !(|flt.reg_ovp);
        status_vec[6]  = !ocp_q;
        status_vec[7]  = !tsd_q;
        status_vec[10:8]  = mcs_pkg::REVISION_CODE;
        status_vec[12:11] = mcs_pkg::DEVICE_CODE;
        status_vec[14] = !reg_fault[3] && !reg_off_q[3];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_mux_out <= 1'b1;
        end else begin
            status_mux_out <= status_vec[ext_q[mcs_pkg::EX_SEL_LSB +: 4]];
        end
    end

    // Decoded configuration for the analog and timing blocks
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_out <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                cfg_out.bridge_blank_periods[i] <= blank_periods(bank0_q[2*i +: 2]);
                cfg_out.sense_external[i] <=
                    bank1_q[mcs_pkg::B1_SENSE_LSB + i*mcs_pkg::B1_SENSE_STEP];
                cfg_out.trip_code[i] <=
                    bank1_q[mcs_pkg::B1_SENSE_LSB + i*mcs_pkg::B1_SENSE_STEP + 1 +: 2];
                cfg_out.converter_on[i] <=
                    !bank0_q[mcs_pkg::B0_CONV_SW_LSB + i] && !reg_off_q[i] && !regs_down;
            end
            for (int j = 0; j < 2; j++) begin
                cfg_out.short_blank_periods[j] <=
                    blank_periods(bank1_q[mcs_pkg::B1_SHORT_LSB + 2*j +: 2]);
            end
            case (bank0_q[mcs_pkg::B0_CHOP_LSB +: 2])
                2'h0:    cfg_out.chop_khz <= 8'h64;
                2'h1:    cfg_out.chop_khz <= 8'h32;
                2'h2:    cfg_out.chop_khz <= 8'h85;
                default: cfg_out.chop_khz <= 8'hC8;
            endcase
            cfg_out.minoff_long <= {bank1_q[mcs_pkg::B1_MINOFF_C],
                                    bank0_q[mcs_pkg::B0_MINOFF_B],
                                    bank0_q[mcs_pkg::B0_MINOFF_A]};
            cfg_out.ldo_on <= !bank0_q[mcs_pkg::B0_LDO_SW] && !reg_off_q[3] && !regs_down;
            cfg_out.deep_sleep     <= deep_sleep;
            cfg_out.thermal_analog <= ext_q[mcs_pkg::EX_TWARN_MODE];
            cfg_out.reset_delay_en <= bank0_q[mcs_pkg::B0_RST_DELAY];
        end
    end

endmodule

// ---- verilog/unused_placeholder_none.sv ----
`timescale 1ns/1ps

// ---- test/mcs_config_monitor.sv ----
`timescale 1ns/1ps
// Port-level checks of the serial setup block, oscillator domain only
module mcs_config_monitor #(
    parameter int PULSE_CYCLES = 20
) (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic                link_clk,
    input wire logic                serial_data,
    input wire logic                latch_pulse_pin,
    input wire logic                drive_standby_l,
    input wire logic                system_reset_in_l,
    input wire logic                supply_undervolt,
    input wire logic                wake_request_l,
    input wire logic [1:0]          startup_select_pin,
    input wire mcs_pkg::mcs_fault_t fault_in,
    input wire logic [2:0]          bridge_enable,
    input wire mcs_pkg::mcs_cfg_t   cfg_out,
    input wire logic                status_mux_out,
    input wire logic                supervisor_reset_out_l
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // External reset held long enough to pass both sync stages and the output register
    sequence s_ext_held;
        !system_reset_in_l [*5];
    endsequence

    a_standby_bridges_off: assert property ((!drive_standby_l) [*4] |-> bridge_enable == 3'h0)
        else $error("bridges drive during standby");
    a_bridges_together: assert property (bridge_enable == 3'h0 || bridge_enable == 3'h7)
        else $error("bridges not switched together");
    a_ext_reset_clears: assert property (s_ext_held |-> cfg_out.chop_khz == 8'h64
        && !cfg_out.deep_sleep && !cfg_out.reset_delay_en) else $error("defaults lost in reset");
    a_uv_clears: assert property (supply_undervolt [*5] |-> cfg_out.minoff_long == 3'h0
        && cfg_out.bridge_blank_periods[2] == 3'h3) else $error("defaults lost in undervoltage");
    a_strap_defaults: assert property (s_ext_held ##1 system_reset_in_l [*5]
        |-> cfg_out.ldo_on == cfg_out.converter_on[1] && !cfg_out.converter_on[0]
        && cfg_out.ldo_on == (startup_select_pin != 2'h0)) else $error("strap defaults wrong");
    a_sleep_bridges_off: assert property (cfg_out.deep_sleep [*2] |-> bridge_enable == 3'h0)
        else $error("bridges drive in deep sleep");
    a_wake_clears_sleep: assert property ((!wake_request_l) [*5] |-> !cfg_out.deep_sleep)
        else $error("wake request ignored");
    a_reset_out_follows: assert property ($fell(system_reset_in_l)
        |-> ##[1:10] !supervisor_reset_out_l) else $error("reset output not asserted");
endmodule

bind mcs_config mcs_config_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) u_mon (.*);

// ---- test/mcs_host_model.sv ----
`timescale 1ns/1ps
// Host side of the serial port; its clock runs only inside frames
module mcs_host_model (
    output logic link_clk,
    output logic serial_data,
    output logic latch_pulse_pin
);
    initial begin
        link_clk        = 1'h0;
        serial_data     = 1'h0;
        latch_pulse_pin = 1'h0;
    end

    // Bit 15 first, each bit held well across its falling clock edge
    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            serial_data = w[i];
            #40 link_clk = 1'h1;
            #40 link_clk = 1'h0;
            #80;
        end
        serial_data = ~serial_data; // Released line must not keep a stale level
    endtask

    // Data level at the strobe rise is the register select, not payload
    task automatic strobe(input logic sel);
        serial_data = sel;
        #40 latch_pulse_pin = 1'h1;
        #80 latch_pulse_pin = 1'h0;
        #40 serial_data = ~sel;
    endtask
endmodule

// ---- test/tb_motor_combo_serial_config.sv ----
`timescale 1ns/1ps
module tb_motor_combo_serial_config;
    logic                clk = 1'h0;
    logic                reset_n = 1'h0;
    logic                drive_standby_l = 1'h0;
    logic                system_reset_in_l = 1'h1;
    logic                supply_undervolt = 1'h0;
    logic                wake_request_l = 1'h1;
    logic [1:0]          startup_select_pin = 2'h1;
    mcs_pkg::mcs_fault_t fault_in = '0;
    logic                link_clk;
    logic                serial_data;
    logic                latch_pulse_pin;
    logic [2:0]          bridge_enable;
    mcs_pkg::mcs_cfg_t   cfg_out;
    logic                status_mux_out;
    logic                supervisor_reset_out_l;
    int                  n_errors = 0;
    int                  compares = 0;
    logic [7:0]          chop_tab [4] = '{8'h64, 8'h32, 8'h85, 8'hC8};
    logic [2:0]          conv_tab [3] = '{3'h0, 3'h2, 3'h6};
    int                  n;
    int                  m;

    mcs_host_model host (.link_clk(link_clk), .serial_data(serial_data),
                         .latch_pulse_pin(latch_pulse_pin));

    // Short pulse length keeps the fault scenarios quick
    mcs_config #(.PULSE_CYCLES(20)) dut (.*);

    always #50 clk = ~clk;

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Outputs are read mid-cycle, after the edge's updates have landed
    task automatic look();
        @(negedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    // Whole frame then strobe; commit lands within a few oscillator cycles
    task automatic wr(input logic sel, input logic [15:0] w);
        host.shift_word(w);
        host.strobe(sel);
        cyc(8);
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run is near 200 us; this margin only catches a hang
    initial begin
        #2_000_000;
        n_errors++;
        end_sim();
    end

    initial begin
        cyc(5);
        reset_n <= 1'h1;
        cyc(4);
        look();
        check(cfg_out.converter_on, 3'h2, "strap defaults");
        check(cfg_out.ldo_on, 1'h1, "regulator default");
        check(status_mux_out, 1'h1, "no fault on A");
        for (int k = 0; k < 4; k++) begin
            wr(1'h0, {4'h0, k[1:0], 3'h0, 1'h1, 6'h39});
            look();
            check(cfg_out.chop_khz, chop_tab[k], "chop rate");
        end
        check(cfg_out.bridge_blank_periods, {3'h5, 3'h4, 3'h2}, "blanking");
        check(cfg_out.converter_on, 3'h7, "converters on");
        wr(1'h0, 16'h80DC);
        look();
        check(cfg_out.short_blank_periods, {3'h5, 3'h3}, "short blank");
        check(cfg_out.sense_external, 3'h1, "sense source");
        check(cfg_out.trip_code[0], 2'h2, "trip code");
        check(cfg_out.minoff_long, 3'h5, "min off");
        check(cfg_out.chop_khz, 8'hC8, "bank 0 kept");
        drive_standby_l <= 1'h1;
        cyc(5);
        look();
        check(bridge_enable, 3'h7, "bridges run");
        wr(1'h0, 16'h0400);
        look();
        check(cfg_out.chop_khz, 8'hC8, "strobe in run ignored");
        cyc(1);
        drive_standby_l <= 1'h0;
        cyc(45);
        host.strobe(1'h0);
        cyc(8);
        look();
        check(cfg_out.chop_khz, 8'h32, "word shifted in run");
        check(bridge_enable, 3'h0, "bridges parked");
        for (int k = 8; k < 16; k++) begin
            wr(1'h1, {12'h0, k[3:0]});
            look();
            check(status_mux_out, (k < 11) ? mcs_pkg::REVISION_CODE[k - 8] :
                  (k < 13) ? mcs_pkg::DEVICE_CODE[k - 11] : 1'h1, "status select");
        end
        wr(1'h1, 16'h0006);
        drive_standby_l <= 1'h1;
        cyc(6);
        fault_in.motor_ocp <= 1'h1;
        n = 0;
        m = 0;
        while (supervisor_reset_out_l === 1'h1 && n < 20) begin
            n++;
            look();
        end
        while (supervisor_reset_out_l === 1'h0 && m < 100) begin
            m++;
            look();
        end
        check(m, 20, "reset pulse length");
        check(bridge_enable, 3'h0, "bridges stopped");
        check(status_mux_out, 1'h0, "motor fault flag");
        cyc(1);
        fault_in.motor_ocp <= 1'h0;
        cyc(6);
        look();
        check(bridge_enable, 3'h0, "stop is latched");
        cyc(1);
        drive_standby_l <= 1'h0;
        cyc(45);
        drive_standby_l <= 1'h1;
        cyc(6);
        look();
        check(bridge_enable, 3'h7, "standby rise releases");
        cyc(1);
        drive_standby_l <= 1'h0;
        for (int s = 0; s < 3; s++) begin
            startup_select_pin <= s[1:0];
            system_reset_in_l <= 1'h0;
            cyc(6);
            system_reset_in_l <= 1'h1;
            cyc(6);
            look();
            check(cfg_out.converter_on, conv_tab[s], "strap capture");
            check(cfg_out.ldo_on, s != 0, "regulator strap");
            cyc(1);
        end
        cyc(4);
        wr(1'h0, 16'h0C00);
        supply_undervolt <= 1'h1;
        cyc(6);
        look();
        check(cfg_out.chop_khz, 8'h64, "undervoltage clears");
        cyc(1);
        supply_undervolt <= 1'h0;
        cyc(10);
        wr(1'h0, 16'h8800);
        look();
        check(cfg_out.deep_sleep, 1'h1, "deep sleep set");
        cyc(1);
        drive_standby_l <= 1'h1;
        cyc(6);
        look();
        check(bridge_enable, 3'h0, "sleep stops bridges");
        cyc(1);
        wake_request_l <= 1'h0;
        cyc(6);
        wake_request_l <= 1'h1;
        look();
        check(cfg_out.deep_sleep, 1'h0, "wake clears sleep");
        cyc(1);
        drive_standby_l <= 1'h0;
        cyc(45);
        wr(1'h0, 16'h1000);
        drive_standby_l <= 1'h1;
        cyc(6);
        fault_in.thermal <= 1'h1;
        cyc(900);
        look();
        check(supervisor_reset_out_l, 1'h1, "reset delayed");
        cyc(200);
        look();
        check(supervisor_reset_out_l, 1'h0, "thermal holds reset");
        check(bridge_enable, 3'h0, "thermal stops motors");
        cyc(1);
        fault_in.thermal <= 1'h0;
        system_reset_in_l <= 1'h0;
        cyc(6);
        system_reset_in_l <= 1'h1;
        cyc(10);
        look();
        check(supervisor_reset_out_l, 1'h1, "reset clears thermal");
        end_sim();
    end
endmodule
